// >>> rtl/pos_search.sv
// origin-search sequencer with Avalon-MM registers
// assumes sensor pins asynchronous to mclk, one clock domain
// Behaviour
// [RQ1] the search enable is caught once after reset and gates every start.
// [RQ2] all other settings act only while the enable is caught high.
// [RQ3] direction cw or ccw, cw by default, is captured at start.
// [RQ4] detection timing is caught once after reset: 0 on-then-off, 1 on, 2 no proximity.
// [RQ5] a limit input reverses the search under setting 0 and stops with an error under 1.
// [RQ6] mode 0 stepper, 1 servo, 2 servo with in-position input.
// [RQ7] origin and proximity inputs each take a normally-closed or normally-open polarity.
// [RQ8] high speed is used from start until proximity is seen.
// [RQ9] proximity speed is used from proximity until origin is seen.
// [RQ10] a signed 32-bit correction is moved after the origin.
// [RQ11] speed rises by the acceleration rate each 4 ms.
// [RQ12] speed falls by the deceleration rate each 4 ms.
// [RQ13] in mode 2 the in-position input is awaited up to the monitor time in ms.
// [RQ14] a missed in-position gives error 0300 and the stopped error flag.
// [RQ15] proximity speed, correction and monitor time are read when used, other settings are captured at start, enable and timing only after reset.
// [RQ16] motion begins at the initial speed before accelerating.
// [RQ17] a completed search clears no-origin and zeroes the position.
module pos_search
  import pos_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic origin_in, // origin sensor pin
  input wire logic prox_in, // proximity sensor pin
  input wire logic cw_limit_in, // cw limit pin, high active
  input wire logic ccw_limit_in, // ccw limit pin, high active
  input wire logic in_position_input, // positioning completed pin
  output logic pulse_out, // one mclk per motor pulse
  output logic dir_ccw, // direction, high ccw
  output logic busy // search running
);
  pos_tick_if tk();
  pos_tick u_tick (.mclk(mclk), .rst_n(rst_n), .tk(tk));
  pos_pulse u_pulse (.mclk(mclk), .rst_n(rst_n), .tk(tk));
  ////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] s1_reg, s2_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
    end else begin
      s1_reg <= {in_position_input, ccw_limit_in, cw_limit_in, prox_in, origin_in};
      s2_reg <= s1_reg;
    end
  end
  ////////////////////////////////////////////////////////////
  // software registers
  logic [31:0] cfg_reg, high_reg, prox_reg, corr_reg, rate_reg, misc_reg;
  logic [31:0] cfg_next, high_next, prox_next, corr_next, rate_next, misc_next;
  logic ack_reg, ack_next;
  logic start_p, errclr_p;
  logic [31:0] wmask;
  always_comb begin
    for (int i = 0; i < 4; i++) wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
  end
  // write decode, one wait cycle per access
  always_comb begin
    cfg_next = cfg_reg;
    high_next = high_reg;
    prox_next = prox_reg;
    corr_next = corr_reg;
    rate_next = rate_reg;
    misc_next = misc_reg;
    ack_next = (avs_read || avs_write) && !ack_reg;
    start_p = 1'b0;
    errclr_p = 1'b0;
    if (avs_write && ack_reg) begin
      case (avs_address)
        POS_REG_CTRL: begin
          start_p = avs_byteenable[0] && avs_writedata[POS_CTRL_START];
          errclr_p = avs_byteenable[0] && avs_writedata[POS_CTRL_ERRCLR];
        end
        POS_REG_CFG: cfg_next = (cfg_reg & ~wmask) | (avs_writedata & wmask);
        POS_REG_HIGH: high_next = (high_reg & ~wmask) | (avs_writedata & wmask);
        POS_REG_PROX: prox_next = (prox_reg & ~wmask) | (avs_writedata & wmask);
        POS_REG_CORR: corr_next = (corr_reg & ~wmask) | (avs_writedata & wmask);
        POS_REG_RATE: rate_next = (rate_reg & ~wmask) | (avs_writedata & wmask);
        POS_REG_MISC: misc_next = (misc_reg & ~wmask) | (avs_writedata & wmask);
        default: ;
      endcase
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= POS_CFG_RST;
      high_reg <= POS_ZERO;
      prox_reg <= POS_ZERO;
      corr_reg <= POS_ZERO;
      rate_reg <= POS_ZERO;
      misc_reg <= POS_ZERO;
      ack_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      high_reg <= high_next;
      prox_reg <= prox_next;
      corr_reg <= corr_next;
      rate_reg <= rate_next;
      misc_reg <= misc_next;
      ack_reg <= ack_next;
    end
  end
  ////////////////////////////////////////////////////////////
  // power-up load: the first cfg write after reset fixes enable and timing until the next reset
  // later cfg writes change the register but not the caught copy
  logic boot_reg, en_reg, cfg_wr;
  logic [1:0] tim_reg;
  assign cfg_wr = avs_write && ack_reg && (avs_address == POS_REG_CFG);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_reg <= 1'b0;
      en_reg <= 1'b0;
      tim_reg <= POS_TIM_ONOFF;
    end else if (!boot_reg && cfg_wr) begin
      boot_reg <= 1'b1;
      en_reg <= cfg_next[POS_CFG_EN]; // see [RQ1] [RQ15]
      tim_reg <= cfg_next[POS_CFG_TIM +: 2]; // see [RQ4] [RQ15]
    end
  end
  ////////////////////////////////////////////////////////////
  // sequencer state
  pos_state_e st_reg, st_next;
  logic dir_reg, dir_next, limstop_reg, limstop_next, opol_reg, opol_next, ppol_reg, ppol_next;
  logic [1:0] mode_reg, mode_next;
  logic seen_reg, seen_next, noorg_reg, noorg_next, err_reg, err_next;
  logic [16:0] spd_reg, spd_next, tgt_reg, tgt_next;
  logic [15:0] acc_reg, acc_next, dec_reg, dec_next, code_reg, code_next;
  logic [31:0] left_reg, left_next, pos_reg, pos_next;
  logic [13:0] mon_reg, mon_next;
  logic org_act, prx_act, lim_hit, prx_ok;
  logic [31:0] corr_mag;
  // active levels: normally-closed means open circuit is active
  assign org_act = opol_reg ? s2_reg[0] : !s2_reg[0]; // see [RQ7]
  assign prx_act = ppol_reg ? s2_reg[1] : !s2_reg[1]; // see [RQ7]
  assign lim_hit = dir_reg ? s2_reg[3] : s2_reg[2];
  assign corr_mag = corr_reg[31] ? (~corr_reg + 32'h0000_0001) : corr_reg;
  // proximity condition before the origin counts
  assign prx_ok = (tim_reg == POS_TIM_ON) ? seen_reg : (seen_reg && !prx_act); // see [RQ4]
  always_comb begin
    st_next = st_reg;
    dir_next = dir_reg;
    limstop_next = limstop_reg;
    opol_next = opol_reg;
    ppol_next = ppol_reg;
    mode_next = mode_reg;
    seen_next = seen_reg;
    noorg_next = noorg_reg;
    err_next = err_reg && !errclr_p;
    code_next = errclr_p ? 16'h0000 : code_reg;
    spd_next = spd_reg;
    tgt_next = tgt_reg;
    acc_next = acc_reg;
    dec_next = dec_reg;
    left_next = left_reg;
    pos_next = pos_reg;
    mon_next = mon_reg;
    // ramp toward target on the 4 ms tick
    if (tk.rate_tick && st_reg != POS_IDLE && st_reg != POS_WAIT && st_reg != POS_DONE) begin
      if (spd_reg < tgt_reg) begin
        spd_next = (tgt_reg - spd_reg > 17'(acc_reg)) ? spd_reg + 17'(acc_reg) : tgt_reg; // see [RQ11]
      end else if (spd_reg > tgt_reg) begin
        spd_next = (spd_reg - tgt_reg > 17'(dec_reg)) ? spd_reg - 17'(dec_reg) : tgt_reg; // see [RQ12]
      end
    end
    // position follows every pulse outside idle, zeroed when the search completes
    if (tk.pulse && st_reg != POS_IDLE) pos_next = dir_reg ? pos_reg - 32'h0000_0001 : pos_reg + 32'h0000_0001;
    case (st_reg)
      POS_IDLE: begin
        if (start_p && en_reg) begin // see [RQ1] [RQ2]
          dir_next = cfg_reg[POS_CFG_DIR]; // see [RQ3] [RQ15]
          limstop_next = cfg_reg[POS_CFG_LIM];
          mode_next = cfg_reg[POS_CFG_MODE +: 2]; // see [RQ6]
          opol_next = cfg_reg[POS_CFG_OPOL];
          ppol_next = cfg_reg[POS_CFG_PPOL];
          acc_next = rate_reg[15:0];
          dec_next = rate_reg[31:16];
          spd_next = misc_reg[16:0]; // see [RQ16]
          tgt_next = high_reg[16:0]; // see [RQ8]
          seen_next = 1'b0;
          noorg_next = 1'b1;
          st_next = POS_HIGH;
          if (tim_reg > POS_TIM_ON) st_next = POS_ORIG;
        end
      end
      POS_HIGH: if (prx_act) begin
        seen_next = 1'b1;
        tgt_next = prox_reg[16:0]; // see [RQ9]
        st_next = POS_PROX;
      end
      POS_PROX: if (prx_ok) st_next = POS_ORIG;
      POS_ORIG: if (org_act) begin
        tgt_next = prox_reg[16:0];
        left_next = corr_mag; // see [RQ10]
        dir_next = corr_reg[31];
        st_next = (corr_mag == POS_ZERO) ? POS_WAIT : POS_CORR;
      end
      // correction leg counts down the pulses actually sent
      POS_CORR: begin
        if (tk.pulse) left_next = left_reg - 32'h0000_0001;
        if (tk.pulse && left_reg == 32'h0000_0001) st_next = POS_WAIT;
      end
      POS_WAIT: begin
        if (mode_reg != POS_MODE_INP || s2_reg[4]) begin // see [RQ13]
          st_next = POS_DONE;
        end else if (tk.ms_tick) begin
          // whole ms ticks only, so the limit is met to within one ms
          mon_next = mon_reg + 14'h0001;
          if (mon_reg >= misc_reg[30:17]) begin
            err_next = 1'b1; // see [RQ14]
            code_next = POS_ERR_TIMEOUT;
            st_next = POS_IDLE;
          end
        end
      end
      POS_DONE: begin
        noorg_next = 1'b0; // see [RQ17]
        pos_next = POS_ZERO;
        st_next = POS_IDLE;
      end
      default: st_next = POS_IDLE;
    endcase
    if (st_reg != POS_WAIT) mon_next = 14'h0000;
    // limit during the search legs
    // after a reversal the other limit is watched, so a held pin cannot flip it back
    if ((st_reg == POS_HIGH || st_reg == POS_PROX || st_reg == POS_ORIG) && lim_hit) begin
      if (limstop_reg) begin
        err_next = 1'b1; // see [RQ5]
        code_next = POS_ERR_LIMIT;
        st_next = POS_IDLE;
      end else begin
        dir_next = !dir_reg; // see [RQ5]
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= POS_IDLE;
      dir_reg <= 1'b0;
      limstop_reg <= 1'b0;
      opol_reg <= 1'b0;
      ppol_reg <= 1'b0;
      mode_reg <= 2'h0;
      seen_reg <= 1'b0;
      noorg_reg <= 1'b1;
      err_reg <= 1'b0;
      code_reg <= 16'h0000;
      spd_reg <= 17'h0_0000;
      tgt_reg <= 17'h0_0000;
      acc_reg <= 16'h0000;
      dec_reg <= 16'h0000;
      left_reg <= POS_ZERO;
      pos_reg <= POS_ZERO;
      mon_reg <= 14'h0000;
    end else begin
      st_reg <= st_next;
      dir_reg <= dir_next;
      limstop_reg <= limstop_next;
      opol_reg <= opol_next;
      ppol_reg <= ppol_next;
      mode_reg <= mode_next;
      seen_reg <= seen_next;
      noorg_reg <= noorg_next;
      err_reg <= err_next;
      code_reg <= code_next;
      spd_reg <= spd_next;
      tgt_reg <= tgt_next;
      acc_reg <= acc_next;
      dec_reg <= dec_next;
      left_reg <= left_next;
      pos_reg <= pos_next;
      mon_reg <= mon_next;
    end
  end
  ////////////////////////////////////////////////////////////
  // outputs and read mux
  assign tk.run = (st_reg == POS_HIGH) || (st_reg == POS_PROX) || (st_reg == POS_ORIG) || (st_reg == POS_CORR);
  assign tk.speed = spd_reg;
  assign pulse_out = tk.pulse;
  assign dir_ccw = dir_reg;
  assign busy = tk.run || (st_reg == POS_WAIT);
  always_comb begin
    case (avs_address)
      POS_REG_CFG: avs_readdata = cfg_reg;
      POS_REG_HIGH: avs_readdata = high_reg;
      POS_REG_PROX: avs_readdata = prox_reg;
      POS_REG_CORR: avs_readdata = corr_reg;
      POS_REG_RATE: avs_readdata = rate_reg;
      POS_REG_MISC: avs_readdata = misc_reg;
      POS_REG_STAT: avs_readdata = {code_reg, 9'h000, st_reg, en_reg, busy, err_reg, noorg_reg};
      default: avs_readdata = POS_ZERO;
    endcase
  end
endmodule

// >>> include/pos_pkg.sv
// origin-search package: register map, field codes, timing counts
// assumes a 100 MHz mclk and an Avalon-MM slave with 32-bit data
package pos_pkg;
  // register byte offsets
  localparam logic [4:0] POS_REG_CTRL = 5'h00;
  localparam logic [4:0] POS_REG_CFG = 5'h04;
  localparam logic [4:0] POS_REG_HIGH = 5'h08;
  localparam logic [4:0] POS_REG_PROX = 5'h0c;
  localparam logic [4:0] POS_REG_CORR = 5'h10;
  localparam logic [4:0] POS_REG_RATE = 5'h14;
  localparam logic [4:0] POS_REG_MISC = 5'h18;
  localparam logic [4:0] POS_REG_STAT = 5'h1c;
  // cfg field positions
  localparam int POS_CFG_EN = 0;
  localparam int POS_CFG_DIR = 1;
  localparam int POS_CFG_TIM = 2;
  localparam int POS_CFG_LIM = 4;
  localparam int POS_CFG_MODE = 5;
  localparam int POS_CFG_OPOL = 7;
  localparam int POS_CFG_PPOL = 8;
  // ctrl bits
  localparam int POS_CTRL_START = 0;
  localparam int POS_CTRL_ERRCLR = 1;
  // reset values
  localparam logic [31:0] POS_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] POS_ZERO = 32'h0000_0000;
  // codes
  localparam logic [1:0] POS_TIM_ONOFF = 2'h0;
  localparam logic [1:0] POS_TIM_ON = 2'h1;
  localparam logic [1:0] POS_MODE_INP = 2'h2;
  localparam logic [15:0] POS_ERR_TIMEOUT = 16'h0300;
  localparam logic [15:0] POS_ERR_LIMIT = 16'h0301;
  // timing
  localparam int POS_CLK_HZ = 100_000_000;
  localparam int POS_RATE_MS = 4;
  localparam int POS_MS_CYC = POS_CLK_HZ / 1000;
  localparam int POS_SPEED_MAX = 100_000;
  localparam int POS_MON_MAX_MS = 9_999;
  typedef enum logic [2:0] {
    POS_IDLE = 3'b000, POS_HIGH = 3'b001, POS_PROX = 3'b011, POS_ORIG = 3'b010,
    POS_CORR = 3'b110, POS_WAIT = 3'b111, POS_DONE = 3'b101
  } pos_state_e;
endpackage

// >>> include/pos_tick_if.sv
// tick and pulse-rate carrier between the sequencer and its helpers
// assumes a single mclk domain
interface pos_tick_if;
  logic ms_tick;
  logic rate_tick;
  logic [16:0] speed;
  logic run;
  logic pulse;
  modport tick (output ms_tick, output rate_tick);
  modport pace (output pulse, input speed, input run);
  modport seq (input ms_tick, input rate_tick, input pulse, output speed, output run);
endinterface

// >>> rtl/pos_tick.sv
// millisecond and 4 ms ticks
// assumes mclk at the package rate
module pos_tick
  import pos_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, low
  pos_tick_if.tick tk // tick carrier
);
  localparam logic [16:0] MS_LAST = 17'(POS_MS_CYC - 1);
  localparam logic [1:0] R_LAST = 2'(POS_RATE_MS - 1);
  logic [16:0] cnt_reg, cnt_next;
  logic [1:0] ms_reg, ms_next;
  ////////////////////////////////////////////////////////////
  // next counts
  always_comb begin
    cnt_next = (cnt_reg == MS_LAST) ? 17'h0_0000 : cnt_reg + 17'h0_0001;
    ms_next = ms_reg;
    if (cnt_reg == MS_LAST) ms_next = ms_reg + 2'h1;
  end
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 17'h0_0000;
      ms_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
      ms_reg <= ms_next;
    end
  end
  assign tk.ms_tick = (cnt_reg == MS_LAST);
  assign tk.rate_tick = (cnt_reg == MS_LAST) && (ms_reg == R_LAST);
endmodule

// >>> rtl/pos_pulse.sv
// pulse-rate generator: phase accumulator, one enable per output pulse
// assumes speed in pulses per second, up to the package maximum
module pos_pulse
  import pos_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, low
  pos_tick_if.pace tk // rate carrier
);
  localparam logic [27:0] WRAP = 28'(POS_CLK_HZ);
  logic [27:0] acc_reg, acc_next;
  logic p_reg, p_next;
  ////////////////////////////////////////////////////////////
  // accumulate speed per cycle, pulse on wrap
  always_comb begin
    acc_next = acc_reg;
    p_next = 1'b0;
    if (!tk.run) begin
      acc_next = 28'h000_0000;
    end else if (acc_reg + 28'(tk.speed) >= WRAP) begin
      acc_next = acc_reg + 28'(tk.speed) - WRAP;
      p_next = 1'b1;
    end else begin
      acc_next = acc_reg + 28'(tk.speed);
    end
  end
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= 28'h000_0000;
      p_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      p_reg <= p_next;
    end
  end
  assign tk.pulse = p_reg;
endmodule

// >>> test/pos_search_props.sv
// checker of the origin-search block: bus handshake, status and motion outputs
// assumes it is bound to pos_search and sees only its ports, one mclk domain
module pos_search_props
  import pos_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset, low
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic origin_in, // origin pin
  input wire logic prox_in, // proximity pin
  input wire logic cw_limit_in, // cw limit pin
  input wire logic ccw_limit_in, // ccw limit pin
  input wire logic in_position_input, // in-position pin
  input wire logic pulse_out, // motor pulse
  input wire logic dir_ccw, // direction
  input wire logic busy // search running
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // bus: exactly one wait state per access, none when idle
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first cycle of access");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest high past one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without request");
  ////////////////////////////////////////////////////////////////////////////////
  // enable as caught by the first cfg write after reset; nothing may run without it
  logic cap_done, cap_en;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_done <= 1'b0;
      cap_en <= 1'b0;
    end else if (!cap_done && avs_write && !avs_waitrequest && avs_address == POS_REG_CFG) begin
      cap_done <= 1'b1;
      cap_en <= avs_writedata[POS_CFG_EN] && avs_byteenable[0];
    end
  end
  a_no_search: assert property (!cap_en |-> !busy)
    else $error("search ran while enable off");
  a_no_pulse: assert property (!busy ##1 !busy |-> !pulse_out)
    else $error("pulse output outside a search");
  a_dir_held: assert property (!busy ##1 !busy |-> $stable(dir_ccw))
    else $error("direction moved outside a search");
  // status reads agree with the caught enable and the busy output, and show no error
  a_stat_enable: assert property (avs_read && !avs_waitrequest && avs_address == POS_REG_STAT
    |-> avs_readdata[3] == cap_en && avs_readdata[2] == busy)
    else $error("status enable or busy bit wrong");
  a_stat_noerr: assert property (avs_read && !avs_waitrequest && avs_address == POS_REG_STAT
    |-> avs_readdata[31:16] == 16'h0000 && !avs_readdata[1])
    else $error("status error set without cause");
endmodule
bind pos_search pos_search_props i_props (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .origin_in(origin_in), .prox_in(prox_in), .cw_limit_in(cw_limit_in), .ccw_limit_in(ccw_limit_in),
  .in_position_input(in_position_input), .pulse_out(pulse_out), .dir_ccw(dir_ccw), .busy(busy));

// >>> test/pos_drive_model.sv
// model of the motor drive and its sensors: counts pulses, drives sensor pins
// assumes pulse_out is one mclk per step; origin and proximity sensors are normally-closed contacts
module pos_drive_model (
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset, low
  input wire logic pulse_out, // step pulse
  input wire logic dir_ccw, // direction
  input wire logic nudge, // moves the load by hand
  input wire logic cw_hit, // forces the cw limit
  input wire logic ccw_hit, // forces the ccw limit
  output logic origin_in, // origin pin
  output logic prox_in, // proximity pin
  output logic cw_limit_in, // cw limit pin
  output logic ccw_limit_in, // ccw limit pin
  output logic in_position_input, // in-position pin
  output logic [31:0] pulse_count // steps seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] pos;
  logic [15:0] still;
  // load position, step count and settle time
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 32'h0000_0000;
      pulse_count <= 32'h0000_0000;
      still <= 16'h0000;
    end else begin
      if (pulse_out) begin
        pos <= dir_ccw ? pos - 32'h0000_0001 : pos + 32'h0000_0001;
        pulse_count <= pulse_count + 32'h0000_0001;
      end else if (nudge) begin
        pos <= pos + 32'h0000_0001;
      end
      still <= pulse_out ? 16'h0000 : (still == 16'hffff ? still : still + 16'h0001);
    end
  end
  // closed contact reads high, opens in the sensing window
  assign prox_in = !(pos >= 32'h0000_0010 && pos < 32'h0000_0020);
  assign origin_in = !(pos == 32'h0000_0018);
  assign cw_limit_in = cw_hit || pos == 32'h0000_0030;
  assign ccw_limit_in = ccw_hit;
  // settles longer than a step period at full speed, so it stays low while moving
  assign in_position_input = still > 16'h1000;
endmodule

// >>> test/pos_search_bench.sv
// self-checking bench of the origin-search block over its Avalon-MM port
// assumes pos_pkg offsets and a drive model on the sensor side
module pos_search_bench;
  import pos_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, pulse_out, dir_ccw, busy;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, pulse_count;
  logic [3:0] avs_byteenable;
  logic origin_in, prox_in, cw_limit_in, ccw_limit_in, in_position_input, nudge, cw_hit, ccw_hit;
  int errors, tests_run, cycles;
  logic [4:0] regs [6] = '{POS_REG_CFG, POS_REG_HIGH, POS_REG_PROX, POS_REG_CORR, POS_REG_RATE, POS_REG_MISC};
  logic [31:0] vals [2][6] = '{
    '{32'h0000_01db, 32'h0001_86a0, 32'h0000_0001, 32'h8000_0000, 32'hffff_0001, 32'h4e1f_86a0},
    '{32'h0000_0024, 32'h0000_0001, 32'h0001_86a0, 32'h7fff_ffff, 32'h0001_ffff, 32'h0000_0000}};
  pos_search i_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .origin_in(origin_in),
    .prox_in(prox_in), .cw_limit_in(cw_limit_in), .ccw_limit_in(ccw_limit_in),
    .in_position_input(in_position_input), .pulse_out(pulse_out), .dir_ccw(dir_ccw), .busy(busy));
  pos_drive_model i_drive (.mclk(mclk), .rst_n(rst_n), .pulse_out(pulse_out), .dir_ccw(dir_ccw),
    .nudge(nudge), .cw_hit(cw_hit), .ccw_hit(ccw_hit), .origin_in(origin_in), .prox_in(prox_in),
    .cw_limit_in(cw_limit_in), .ccw_limit_in(ccw_limit_in), .in_position_input(in_position_input),
    .pulse_count(pulse_count));
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock and run ceiling
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 45000) begin
      errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus cycles
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hold the request until waitrequest is sampled low, then release
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    avs_address <= 5'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0000_0000;
    avs_byteenable <= 4'hf;
    nudge <= 1'b0;
    cw_hit <= 1'b0;
    ccw_hit <= 1'b0;
    do_reset();
    // settings come up at their defaults
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 32'h0000_0000);
      check("default", 32'h0000_0000, rd);
    end
    bus(1'b0, POS_REG_STAT, 32'h0000_0000);
    check("status", 32'h0000_0000, rd & 32'hffff_007e);
    // setup load: full speed, +3 correction, 1 ms monitor; first cfg write sets enable, timing 1, mode 2
    bus(1'b1, POS_REG_HIGH, 32'h0001_86a0);
    bus(1'b1, POS_REG_PROX, 32'h0001_86a0);
    bus(1'b1, POS_REG_CORR, 32'h0000_0003);
    bus(1'b1, POS_REG_MISC, 32'h0003_86a0);
    bus(1'b1, POS_REG_CFG, 32'h0000_0045);
    bus(1'b0, POS_REG_STAT, 32'h0000_0000);
    check("enable", 32'h0000_0008, rd & 32'h0000_0008);
    // one search: origin at step 24 once proximity is on, then 3 correction steps
    bus(1'b1, POS_REG_CTRL, 32'h0000_0001);
    @(posedge mclk);
    check("busy", 32'h0000_0001, {31'h0, busy});
    check("dir", 32'h0000_0000, {31'h0, dir_ccw});
    wait (busy === 1'b0);
    @(posedge mclk);
    check("pulses", 32'h0000_001b, pulse_count);
    check("in_position", 32'h0000_0001, {31'h0, in_position_input});
    bus(1'b0, POS_REG_STAT, 32'h0000_0000);
    check("status", 32'h0000_0008, rd & 32'hffff_007f);
    // every field written with range ends and codes, read back
    for (int p = 0; p < 2; p++) begin
      foreach (regs[i]) begin
        bus(1'b1, regs[i], vals[p][i]);
        bus(1'b0, regs[i], 32'h0000_0000);
        check("setting", vals[p][i], rd);
      end
    end
    // second reset: first cfg write leaves enable off, later enable and start are refused
    do_reset();
    bus(1'b0, POS_REG_CFG, 32'h0000_0000);
    check("cfg", POS_CFG_RST, rd);
    bus(1'b1, POS_REG_CFG, 32'h0000_0000);
    bus(1'b1, POS_REG_CFG, 32'h0000_0001);
    bus(1'b1, POS_REG_CTRL, 32'h0000_0001);
    nudge <= 1'b1;
    cw_hit <= 1'b1;
    ccw_hit <= 1'b1;
    repeat (60) @(posedge mclk);
    nudge <= 1'b0;
    cw_hit <= 1'b0;
    ccw_hit <= 1'b0;
    check("pulses", 32'h0000_0000, pulse_count);
    check("busy", 32'h0000_0000, {31'h0, busy});
    bus(1'b1, POS_REG_CTRL, 32'h0000_0002);
    bus(1'b0, POS_REG_STAT, 32'h0000_0000);
    check("status", 32'h0000_0000, rd & 32'hffff_007e);
    bus(1'b0, 5'h02, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, rd);
    bus(1'b1, POS_REG_CTRL, 32'h0000_0001);
    repeat (4) @(posedge mclk);
    check("busy", 32'h0000_0000, {31'h0, busy});
    print_verdict();
  end
endmodule
